// ---- core/adir_pkg.sv ----
// Purpose: constants for the converter event, result and threshold registers
// Assumes: APB slave with 32-bit data, byte addresses
// Notes:   offsets are byte addresses
package adir_pkg;
    localparam logic [7:0]  OFF_MASKED_STATUS = 8'h08;
    localparam logic [7:0]  OFF_IRQ_MASK      = 8'h0C;
    localparam logic [7:0]  OFF_RAW_STATUS    = 8'h10;
    localparam logic [7:0]  OFF_RESULT        = 8'h14;
    localparam logic [7:0]  OFF_CAL_OFFSET    = 8'h18;
    localparam logic [7:0]  OFF_CONV_STATE    = 8'h20;
    localparam logic [7:0]  OFF_UPPER_LIMIT   = 8'h24;
    localparam logic [7:0]  OFF_LOWER_LIMIT   = 8'h28;
    localparam logic [7:0]  OFF_IRQ_ENABLE    = 8'h30;
    localparam logic [7:0]  OFF_IRQ_CLEAR     = 8'h34;
    localparam logic [7:0]  OFF_CONTROL       = 8'h38;
    localparam int          BIT_CAL_DONE      = 0;
    localparam int          BIT_BUSY          = 1;
    localparam int          BIT_CONV_DONE     = 2;
    localparam int          BIT_WIN_MATCH     = 3;
    localparam int          BIT_BYPASS        = 0;
    localparam int          BIT_WIN_ENABLE    = 1;
    localparam logic [3:0]  EVT_MASK          = 4'hD;
    localparam logic [3:0]  RST_IRQ_MASK      = 4'hF;
    localparam logic [31:0] RST_UPPER_LIMIT   = 32'h0FFFFFFF;
    localparam logic [31:0] RST_LOWER_LIMIT   = 32'h00000000;
    localparam logic [31:0] RST_CAL_OFFSET    = 32'h00000000;
endpackage

// ---- core/adir_regs.sv ----
// Purpose: event flags, interrupt, result, offset and window registers of a converter
// Assumes: APB slave, zero wait states, converter core signals on the same clock
// Notes:   status registers clear on read; set wins over a read clear
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps

// Overview of operation
// - Calibration completion sets status bit 0, cleared by reading the status register.
// - Conversion completion sets status bit 2, cleared by reading the status register.
// - With window compare on, bit 3 is 1 when the result lies within the limits, read clears.
// - The window flag is re-evaluated on every end of conversion with the new value.
// - The mask register holds bits 3:0, bit 1 masks no event; 0 enables, 1 disables, reset is 1.
// - A raw status register shows the same flags and reading it also clears them.
// - With the filter in use the result is two's complement in bits 31:16.
// - The offset register holds a 16-bit offset in the half chosen by bypass, reset zero.
// - Converter state bit 1 is 1 while a conversion is in progress.
// - The upper window limit is a 32-bit read-write register with its printed reset.
// - The lower window limit is a 32-bit read-write register resetting to zero.
module adir_regs
    import adir_pkg::*;
(
    input  wire logic        I_CLOCK,       // system clock, 200 MHz
    input  wire logic        I_ARST_N,      // asynchronous reset, active low
    input  wire logic        I_PSEL,        // apb select
    input  wire logic        I_PENABLE,     // apb access phase
    input  wire logic        I_PWRITE,      // apb direction
    input  wire logic [7:0]  I_PADDR,       // apb byte address
    input  wire logic [31:0] I_PWDATA,      // apb write data
    input  wire logic [3:0]  I_PSTRB,       // apb byte strobes
    output logic      [31:0] O_PRDATA,      // apb read data
    output logic             O_PREADY,      // apb ready
    output logic             O_PSLVERR,     // apb error, unmapped address
    input  wire logic        I_CAL_DONE,    // calibration finished pulse
    input  wire logic        I_CONV_DONE,   // conversion finished pulse
    input  wire logic        I_CONV_ACTIVE, // conversion in progress level
    input  wire logic [15:0] I_CONV_VALUE,  // converted sample, two's complement
    input  wire logic [15:0] I_CAL_VALUE,   // calibration offset from core
    output logic             O_BYPASS,      // filter bypass setting
    output logic             O_IRQ,         // interrupt request
    output logic             O_EVT_IRQ      // enabled event interrupt
);

    ////////////////////////////////////////////////////////////////////////
    logic [3:0]  raw_flags;
    logic [3:0]  irq_mask;
    logic [3:0]  irq_enable;
    logic [3:0]  evt_sticky;
    logic [31:0] result;
    logic [31:0] cal_offset;
    logic [31:0] upper_limit;
    logic [31:0] lower_limit;
    logic        bypass;
    logic        win_enable;
    logic        busy;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    // sign-extends a sample so it compares against the 32-bit limits
    function automatic logic signed [31:0] sext16(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    wire         setup_ph   = I_PSEL && !I_PENABLE;
    wire         wr_access  = setup_ph && I_PWRITE;
    wire         rd_access  = setup_ph && !I_PWRITE;
    wire         hit_mstat  = I_PADDR == OFF_MASKED_STATUS;
    wire         hit_mask   = I_PADDR == OFF_IRQ_MASK;
    wire         hit_rstat  = I_PADDR == OFF_RAW_STATUS;
    wire         hit_res    = I_PADDR == OFF_RESULT;
    wire         hit_off    = I_PADDR == OFF_CAL_OFFSET;
    wire         hit_state  = I_PADDR == OFF_CONV_STATE;
    wire         hit_hi     = I_PADDR == OFF_UPPER_LIMIT;
    wire         hit_lo     = I_PADDR == OFF_LOWER_LIMIT;
    wire         hit_ien    = I_PADDR == OFF_IRQ_ENABLE;
    wire         hit_iclr   = I_PADDR == OFF_IRQ_CLEAR;
    wire         hit_ctl    = I_PADDR == OFF_CONTROL;
    wire         mapped     = hit_mstat | hit_mask | hit_rstat | hit_res | hit_off | hit_state
                              | hit_hi | hit_lo | hit_ien | hit_iclr | hit_ctl;
    wire         stat_read  = rd_access && (hit_mstat || hit_rstat);
    wire [3:0]   masked     = raw_flags & ~irq_mask & EVT_MASK;
    wire [15:0]  conv_in    = I_CONV_VALUE;
    wire         in_window  = (sext16(conv_in) <= $signed(upper_limit))
                              && (sext16(conv_in) >= $signed(lower_limit));
    wire [3:0]   new_events = {I_CONV_DONE && win_enable && in_window,
                               I_CONV_DONE, 1'b0, I_CAL_DONE};
    wire [31:0]  wd_mask    = merge({28'h0000000, irq_mask}, I_PWDATA, I_PSTRB);
    wire [31:0]  wd_ctl     = merge({30'h00000000, win_enable, bypass}, I_PWDATA, I_PSTRB);
    wire [31:0]  wd_ien     = merge({28'h0000000, irq_enable}, I_PWDATA, I_PSTRB);

    // read mux
    wire [31:0] rd_word =
        hit_mstat ? {28'h0000000, masked} :
        hit_mask  ? {28'h0000000, irq_mask} :
        hit_rstat ? {28'h0000000, raw_flags} :
        hit_res   ? result :
        hit_off   ? cal_offset :
        hit_state ? {30'h00000000, busy, 1'b0} :
        hit_hi    ? upper_limit :
        hit_lo    ? lower_limit :
        hit_ien   ? {28'h0000000, irq_enable} :
        hit_ctl   ? {30'h00000000, win_enable, bypass} :
        hit_iclr  ? 32'h00000000 : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // bus answer, one access phase, no wait
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_PRDATA  <= 32'h00000000;
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY  <= setup_ph;
            O_PSLVERR <= setup_ph && !mapped;
            O_PRDATA  <= rd_access ? rd_word : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event flags: a new event beats the read clear; window flag replaced each conversion
    wire [3:0] flag_keep  = stat_read ? 4'h0 : raw_flags;
    wire       win_next   = I_CONV_DONE ? new_events[BIT_WIN_MATCH]
                                        : flag_keep[BIT_WIN_MATCH];
    wire [3:0] next_flags = {win_next, (flag_keep[2:0] | new_events[2:0])} & EVT_MASK;

    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            raw_flags <= 4'h0;
        end else begin
            raw_flags <= next_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            irq_mask    <= RST_IRQ_MASK;
            irq_enable  <= 4'h0;
            upper_limit <= RST_UPPER_LIMIT;
            lower_limit <= RST_LOWER_LIMIT;
            bypass      <= 1'b0;
            win_enable  <= 1'b0;
        end else if (wr_access) begin
            if (hit_mask) begin
                irq_mask <= wd_mask[3:0];
            end
            if (hit_ien) begin
                irq_enable <= next_ien;
            end
            if (hit_hi) begin
                upper_limit <= merge(upper_limit, I_PWDATA, I_PSTRB);
            end
            if (hit_lo) begin
                lower_limit <= merge(lower_limit, I_PWDATA, I_PSTRB);
            end
            if (hit_ctl) begin
                bypass     <= wd_ctl[BIT_BYPASS];
                win_enable <= wd_ctl[BIT_WIN_ENABLE];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result and offset, steered by the bypass setting
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            result     <= 32'h00000000;
            cal_offset <= RST_CAL_OFFSET;
        end else begin
            if (I_CONV_DONE) begin
                result <= bypass ? {16'h0000, I_CONV_VALUE}
                                 : {I_CONV_VALUE, 16'h0000};
            end
            if (I_CAL_DONE) begin
                cal_offset <= bypass ? {16'h0000, I_CAL_VALUE}
                                     : {I_CAL_VALUE, 16'h0000};
            end else if (wr_access && hit_off) begin
                cal_offset <= merge(cal_offset, I_PWDATA, I_PSTRB);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // busy, sticky interrupt status, outputs
    wire [3:0] clr_bits   = (wr_access && hit_iclr) ? I_PWDATA[3:0] : 4'h0;
    wire [3:0] next_stick = (evt_sticky & ~clr_bits) | (new_events & EVT_MASK);
    // mask and enable as they stand after this edge, so the outputs track a write at once
    wire [3:0] next_mask  = (wr_access && hit_mask) ? wd_mask[3:0] : irq_mask;
    wire [3:0] next_ien   = (wr_access && hit_ien) ? (wd_ien[3:0] & EVT_MASK) : irq_enable;

    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            busy       <= 1'b0;
            evt_sticky <= 4'h0;
            O_IRQ      <= 1'b0;
            O_EVT_IRQ  <= 1'b0;
            O_BYPASS   <= 1'b0;
        end else begin
            busy       <= I_CONV_ACTIVE;
            evt_sticky <= next_stick;
            O_IRQ      <= |(next_flags & ~next_mask & EVT_MASK);
            O_EVT_IRQ  <= |(next_stick & next_ien);
            O_BYPASS   <= bypass;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_cal_sets;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        I_CAL_DONE |=> raw_flags[BIT_CAL_DONE];
    endproperty
    a_cal_sets: assert property (p_cal_sets) else $error("cal flag not set");

    property p_conv_sets;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        I_CONV_DONE |=> raw_flags[BIT_CONV_DONE];
    endproperty
    a_conv_sets: assert property (p_conv_sets) else $error("conv flag not set");

    property p_read_clears;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (stat_read && !I_CAL_DONE && !I_CONV_DONE) |=> raw_flags == 4'h0;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear");

    property p_win_eval;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        I_CONV_DONE |=> raw_flags[BIT_WIN_MATCH] == $past(win_enable && in_window);
    endproperty
    a_win_eval: assert property (p_win_eval) else $error("window flag wrong");

    property p_irq;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        O_IRQ == |(raw_flags & ~irq_mask & EVT_MASK);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    property p_busy;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        I_CONV_ACTIVE |=> busy;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not shown");

    property p_result_half;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (I_CONV_DONE && !bypass) |=> result[31:16] == $past(I_CONV_VALUE);
    endproperty
    a_result_half: assert property (p_result_half) else $error("result half wrong");

    property p_ready;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        setup_ph |=> O_PREADY ##1 !O_PREADY || (I_PSEL && !I_PENABLE);
    endproperty
    a_ready: assert property (p_ready) else $error("apb ready wrong");

    property p_win_off;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (I_CONV_DONE && !win_enable) |=> !raw_flags[BIT_WIN_MATCH];
    endproperty
    a_win_off: assert property (p_win_off) else $error("window flag while off");

    property p_flag_hold;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (!stat_read && !I_CONV_DONE && !I_CAL_DONE) |=> raw_flags == $past(raw_flags);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flags changed unasked");

    property p_masked_read;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (rd_access && hit_mstat) |=> O_PRDATA == {28'h0000000, $past(masked)};
    endproperty
    a_masked_read: assert property (p_masked_read) else $error("masked read wrong");

    property p_raw_read;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (rd_access && hit_rstat) |=> O_PRDATA == {28'h0000000, $past(raw_flags)};
    endproperty
    a_raw_read: assert property (p_raw_read) else $error("raw read wrong");

    property p_result_low;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (I_CONV_DONE && bypass) |=> result[15:0] == $past(I_CONV_VALUE);
    endproperty
    a_result_low: assert property (p_result_low) else $error("result low half wrong");

    property p_offset_low;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (I_CAL_DONE && bypass) |=> cal_offset[15:0] == $past(I_CAL_VALUE);
    endproperty
    a_offset_low: assert property (p_offset_low) else $error("offset low wrong");

    property p_offset_high;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (I_CAL_DONE && !bypass) |=> cal_offset[31:16] == $past(I_CAL_VALUE);
    endproperty
    a_offset_high: assert property (p_offset_high) else $error("offset high wrong");

    property p_busy_off;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        !I_CONV_ACTIVE |=> !busy;
    endproperty
    a_busy_off: assert property (p_busy_off) else $error("busy stuck");

    property p_evt_irq;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        O_EVT_IRQ == |(evt_sticky & irq_enable);
    endproperty
    a_evt_irq: assert property (p_evt_irq) else $error("event irq mismatch");

    property p_prdata_idle;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        !O_PREADY |-> O_PRDATA == 32'h00000000;
    endproperty
    a_prdata_idle: assert property (p_prdata_idle) else $error("read data outside access");

    property p_err_ready;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        O_PSLVERR |-> O_PREADY;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");

    c_cal:  cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N) I_CAL_DONE);
    c_win:  cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
                            I_CONV_DONE && win_enable && in_window);
    c_irq:  cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N) O_IRQ);
    c_race: cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N) stat_read && I_CONV_DONE);
    c_byp:  cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N) I_CONV_DONE && bypass);

endmodule

// ---- testbench/adir_regs_test.sv ----
// Purpose: self-checking bench for the converter event, result and threshold registers
// Assumes: zero-wait apb slave, event inputs are one-cycle pulses
// Notes:   bench drives every port itself, no partner model
`timescale 1ns/1ps
module adir_regs_test;
    import adir_pkg::*;
    logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, er, bypass, irq, evt_irq;
    logic        cal = 1'b0, conv = 1'b0, active = 1'b0;
    logic [15:0] conv_value = 16'h0, cal_value = 16'h0;
    int          fail_count = 0, n_tests = 0, cyc = 0;
    adir_regs adir_regs_inst (.I_CLOCK(clk), .I_ARST_N(arst_n), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_CAL_DONE(cal), .I_CONV_DONE(conv), .I_CONV_ACTIVE(active),
        .I_CONV_VALUE(conv_value), .I_CAL_VALUE(cal_value), .O_BYPASS(bypass),
        .O_IRQ(irq), .O_EVT_IRQ(evt_irq));
    always #2.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic pulse(input logic is_cal, input logic [15:0] v);
        @(posedge clk);
        if (is_cal) begin cal <= 1'b1; cal_value <= v; end
        else begin conv <= 1'b1; conv_value <= v; end
        @(posedge clk);
        cal <= 1'b0; conv <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        apb(0, OFF_IRQ_MASK, 0);
        chk("mask_rst", rd, 32'h0000000F);
        chk("slverr_ok", {31'h0, er}, 32'h0);
        apb(0, OFF_UPPER_LIMIT, 0);
        chk("upper_rst", rd, 32'h0FFFFFFF);
        apb(0, OFF_LOWER_LIMIT, 0);
        chk("lower_rst", rd, 32'h00000000);
        apb(0, OFF_CAL_OFFSET, 0);
        chk("offset_rst", rd, 32'h00000000);
        apb(0, OFF_RAW_STATUS, 0);
        chk("raw_rst", rd, 32'h00000000);
        apb(0, OFF_MASKED_STATUS, 0);
        chk("masked_rst", rd, 32'h00000000);
        apb(0, OFF_CONV_STATE, 0);
        chk("state_rst", rd, 32'h00000000);
    endtask
    task automatic t_masking();
        pulse(1, 16'h0000);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        apb(0, OFF_RAW_STATUS, 0);
        chk("raw_cal", rd, 32'h00000001);
        apb(0, OFF_RAW_STATUS, 0);
        chk("raw_clr", rd, 32'h00000000);
        apb(1, OFF_IRQ_MASK, 32'h0000000A);
        apb(0, OFF_IRQ_MASK, 0);
        chk("mask_rw", rd, 32'h0000000A);
        pulse(1, 16'h0000);
        chk("irq_cal", {31'h0, irq}, 32'h1);
        apb(0, OFF_MASKED_STATUS, 0);
        chk("msk_cal", rd, 32'h00000001);
        repeat (2) @(posedge clk);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        apb(1, OFF_CONTROL, 32'h2);
        pulse(0, 16'h0001);
        chk("irq_conv", {31'h0, irq}, 32'h1);
        apb(0, OFF_MASKED_STATUS, 0);
        chk("msk_conv", rd, 32'h00000004);
        apb(0, OFF_RAW_STATUS, 0);
        chk("raw_after", rd, 32'h00000000);
        apb(1, OFF_IRQ_MASK, 32'h0000000F);
    endtask
    task automatic t_window();
        logic [15:0] vals [5] = '{16'hFFFE, 16'h0064, 16'h0065, 16'hFFFA, 16'hFFFB};
        logic        hit  [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        pstrb <= 4'h3;
        apb(1, OFF_UPPER_LIMIT, 32'h12345678);
        pstrb <= 4'hF;
        apb(0, OFF_UPPER_LIMIT, 0);
        chk("upper_strb", rd, 32'h0FFF5678);
        apb(1, OFF_LOWER_LIMIT, 32'hFFFFFFFB);
        apb(1, OFF_UPPER_LIMIT, 32'h00000064);
        apb(0, OFF_UPPER_LIMIT, 0);
        chk("upper_rw", rd, 32'h00000064);
        apb(0, OFF_LOWER_LIMIT, 0);
        chk("lower_rw", rd, 32'hFFFFFFFB);
        apb(1, OFF_CONTROL, 32'h2);
        for (int i = 0; i < 5; i++) begin
            pulse(0, vals[i]);
            apb(0, OFF_RAW_STATUS, 0);
            chk("win_flag", rd, {28'h0, hit[i], 3'b100});
            apb(0, OFF_RESULT, 0);
            chk("result_hi", {16'h0, rd[31:16]}, {16'h0, vals[i]});
        end
        // a miss after a hit, no read between: the flag must be replaced
        pulse(0, 16'h0000);
        pulse(0, 16'h0065);
        apb(0, OFF_RAW_STATUS, 0);
        chk("win_replaced", rd, 32'h00000004);
        apb(1, OFF_CONTROL, 32'h0);
        pulse(0, 16'h0010);
        apb(0, OFF_RAW_STATUS, 0);
        chk("win_off", rd, 32'h00000004);
    endtask
    task automatic t_bypass_offset();
        apb(1, OFF_CAL_OFFSET, 32'h55AA33CC);
        apb(0, OFF_CAL_OFFSET, 0);
        chk("offset_rw", rd, 32'h55AA33CC);
        pulse(1, 16'h1234);
        apb(0, OFF_CAL_OFFSET, 0);
        chk("offset_hi", {16'h0, rd[31:16]}, 32'h1234);
        apb(1, OFF_CONTROL, 32'h1);
        @(posedge clk);
        chk("bypass", {31'h0, bypass}, 32'h1);
        pulse(1, 16'hABCD);
        apb(0, OFF_CAL_OFFSET, 0);
        chk("offset_lo", {16'h0, rd[15:0]}, 32'hABCD);
        repeat (3) pulse(0, 16'h0000);
        pulse(0, 16'h8001);
        apb(0, OFF_RESULT, 0);
        chk("result_lo", {16'h0, rd[15:0]}, 32'h8001);
        apb(1, OFF_CONTROL, 32'h0);
        pulse(1, 16'h0000);
    endtask
    task automatic t_busy_irq_unmapped();
        @(posedge clk) active <= 1'b1;
        apb(0, OFF_CONV_STATE, 0);
        chk("busy_on", rd, 32'h00000002);
        @(posedge clk) active <= 1'b0;
        apb(0, OFF_CONV_STATE, 0);
        chk("busy_off", rd, 32'h00000000);
        apb(1, OFF_IRQ_CLEAR, 32'hD);
        apb(1, OFF_IRQ_ENABLE, 32'h4);
        chk("evt_idle", {31'h0, evt_irq}, 32'h0);
        pulse(0, 16'h0002);
        chk("evt_set", {31'h0, evt_irq}, 32'h1);
        apb(1, OFF_IRQ_CLEAR, 32'h4);
        repeat (2) @(posedge clk);
        chk("evt_clr", {31'h0, evt_irq}, 32'h0);
        apb(1, 8'h3C, 32'hFFFFFFFF);
        chk("err_wr", {31'h0, er}, 32'h1);
        apb(0, 8'h3C, 0);
        chk("err_rd", {er, rd[30:0]}, 32'h80000000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        t_reset_values();
        t_masking();
        t_window();
        t_bypass_offset();
        t_busy_irq_unmapped();
        end_of_test();
    end
endmodule
